// ---- hdl/pdws_map.svh ----
// Constants of the power-down wake sequencer: fuse codes, counts, times.
// Assumes inclusion by the sequencer only.
`ifndef PDWS_MAP_SVH
`define PDWS_MAP_SVH

// Sleep mode codes
`define PDWS_SM_POWER_DOWN 3'h2
`define PDWS_SM_POWER_SAVE 3'h3

// Clock source code that selects the external clock input
`define PDWS_CKSEL_EXT 4'h0

// Start-up field codes
`define PDWS_SUT_NONE 2'h0
`define PDWS_SUT_FAST 2'h1
`define PDWS_SUT_SLOW 2'h2

// Selected-clock cycle counts
`define PDWS_WAKE_CK 4'h6
`define PDWS_RESET_CK 4'hE

// Core clock and internal oscillator rates in kHz
`define PDWS_CORE_KHZ 125000
`define PDWS_INT_OSC_KHZ 128
`define PDWS_INT_DIV (`PDWS_CORE_KHZ / `PDWS_INT_OSC_KHZ)

// Extra reset delays in microseconds
`define PDWS_INT_FAST_US 4000
`define PDWS_INT_SLOW_US 64000
`define PDWS_EXT_FAST_US 4100
`define PDWS_EXT_SLOW_US 65000
`define PDWS_US_TO_CYC(us) ((us) * (`PDWS_CORE_KHZ / 1000))

// Reset values
`define PDWS_FUSE_RST 6'h00

`endif

// ---- hdl/pdws_pkg.sv ----
// Types of the power-down wake sequencer.
// Assumes nothing beyond the constants header.
package pdws_pkg;

  typedef enum logic [2:0] {
    PDWS_RST_CK,
    PDWS_RST_MS,
    PDWS_RUN,
    PDWS_SLEEP,
    PDWS_WAKE
  } pdws_state_e;

  typedef struct packed {
    logic ext_reset;
    logic wdt_reset;
    logic wdt_irq;
    logic bod_reset;
    logic twi_match;
    logic ext_level;
    logic pin_change;
    logic async_timer_irq;
    logic spm_ee_ready;
  } pdws_wake_s;

  typedef struct packed {
    logic [3:0] clock_source_fuses;
    logic [1:0] startup_time_fuses;
  } pdws_fuse_s;

endpackage

// ---- hdl/pdws_sequencer.sv ----
// Power-down and power-save entry, wake-up and start-up delay sequencer.
// Assumes wake sources and the external clock arrive asynchronously;
// the CPU sleep strobe, mode bits and fuses come from core_clk logic.
`timescale 1ns/1ps
`include "pdws_map.svh"

// How it works
// - On the internal oscillator, wake takes 6 cycles and reset takes 14 plus 0, 4 or 64 ms.
// - On the external clock, wake takes 6 cycles and reset takes 14 plus 0, 4.1 or 65 ms.
// - The external clock input is used only when the clock-source fuses read 0000.
// - Sleep mode 010 with the sleep strobe enters power-down.
// - In sleep the external oscillator stops while wake detection stays alive.
// - Power-down ends only on reset, watchdog, brown-out, address match, level or pin change.
// - In sleep every generated clock to the core is halted.
// - A level that is gone by the end of start-up still wakes but raises no interrupt.
// - Execution resumes only after the start-up delay set by the fuses.
// - Power-save adds timer and ready wakes; the timer runs in sleep only in async mode.
module pdws_sequencer
  import pdws_pkg::*;
#(
  parameter int unsigned INT_FAST_CYC = `PDWS_US_TO_CYC(`PDWS_INT_FAST_US),
  parameter int unsigned INT_SLOW_CYC = `PDWS_US_TO_CYC(`PDWS_INT_SLOW_US),
  parameter int unsigned EXT_FAST_CYC = `PDWS_US_TO_CYC(`PDWS_EXT_FAST_US),
  parameter int unsigned EXT_SLOW_CYC = `PDWS_US_TO_CYC(`PDWS_EXT_SLOW_US)
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic sleep_exec,
  input wire logic [2:0] sleep_mode_select,
  input wire pdws_fuse_s fuses,
  input wire logic external_clock_input,
  input wire pdws_wake_s wake_in,
  input wire logic async_timer_async_mode,
  output logic sys_clk_en,
  output logic core_reset_hold,
  output logic ext_osc_en,
  output logic async_timer_en,
  output logic level_irq_req,
  output logic sleeping
);

  localparam logic [9:0] INT_DIV_LAST = 10'(`PDWS_INT_DIV - 1);

  ////////////////////////////////////////////////////////////////////
  // Synchronisers

  pdws_wake_s wake_s1_r;
  pdws_wake_s wake_s2_r;
  logic [2:0] eclk_r;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_s1_r <= '0;
      wake_s2_r <= '0;
      eclk_r <= 3'h0;
    end else begin
      wake_s1_r <= wake_in;
      wake_s2_r <= wake_s1_r;
      eclk_r <= {eclk_r[1:0], external_clock_input};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Selected clock tick

  pdws_fuse_s fuse_r;
  pdws_fuse_s fuse_nxt;
  logic [9:0] div_r;
  logic [9:0] div_nxt;
  logic use_ext;
  logic int_tick;
  logic ext_tick;
  logic tick;

  // Sources other than the external code fall back to the internal one
  assign use_ext = (fuse_r.clock_source_fuses == `PDWS_CKSEL_EXT);
  assign int_tick = (div_r == INT_DIV_LAST);
  // Reads only the second and third stages
  assign ext_tick = eclk_r[1] & ~eclk_r[2];
  assign tick = use_ext ? ext_tick : int_tick;

  always_comb begin
    div_nxt = int_tick ? 10'h000 : div_r + 10'h001;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_r <= 10'h000;
    end else begin
      div_r <= div_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Extra reset delay

  logic [23:0] extra_cyc;

  always_comb begin
    extra_cyc = 24'h00_0000;
    // Reserved start-up code adds nothing
    case (fuse_r.startup_time_fuses)
      `PDWS_SUT_FAST: begin
        extra_cyc = use_ext ? 24'(EXT_FAST_CYC) : 24'(INT_FAST_CYC);
      end
      `PDWS_SUT_SLOW: begin
        extra_cyc = use_ext ? 24'(EXT_SLOW_CYC) : 24'(INT_SLOW_CYC);
      end
      default: begin
        extra_cyc = 24'h00_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer

  pdws_state_e state_r;
  pdws_state_e state_nxt;
  logic [3:0] ck_cnt_r;
  logic [3:0] ck_cnt_nxt;
  logic [23:0] ms_cnt_r;
  logic [23:0] ms_cnt_nxt;
  logic save_r;
  logic save_nxt;
  logic level_irq_nxt;
  logic rst_req;
  logic pd_wake;
  logic any_wake;
  logic mode_ok;

  assign rst_req = wake_s2_r.ext_reset | wake_s2_r.wdt_reset | wake_s2_r.bod_reset;
  assign pd_wake = rst_req | wake_s2_r.wdt_irq | wake_s2_r.twi_match
                 | wake_s2_r.ext_level | wake_s2_r.pin_change;
  assign any_wake = pd_wake
                  | (save_r & (wake_s2_r.async_timer_irq | wake_s2_r.spm_ee_ready));
  // Other sleep modes lie outside this block; the strobe is ignored
  assign mode_ok = (sleep_mode_select == `PDWS_SM_POWER_DOWN)
                 | (sleep_mode_select == `PDWS_SM_POWER_SAVE);

  always_comb begin
    state_nxt = state_r;
    ck_cnt_nxt = ck_cnt_r;
    ms_cnt_nxt = ms_cnt_r;
    save_nxt = save_r;
    level_irq_nxt = 1'b0;
    // Fuses follow their pins only while the reset cycle count (PDWS_RST_CK) runs
    fuse_nxt = (state_r == PDWS_RST_CK) ? fuses : fuse_r;
    case (state_r)
      PDWS_RST_CK: begin
        if (tick) begin
          if (ck_cnt_r == `PDWS_RESET_CK - 4'h1) begin
            ck_cnt_nxt = 4'h0;
            if (extra_cyc == 24'h00_0000) begin
              state_nxt = PDWS_RUN;
            end else begin
              ms_cnt_nxt = extra_cyc - 24'h00_0001;
              state_nxt = PDWS_RST_MS;
            end
          end else begin
            ck_cnt_nxt = ck_cnt_r + 4'h1;
          end
        end
      end
      PDWS_RST_MS: begin
        if (ms_cnt_r == 24'h00_0000) begin
          state_nxt = PDWS_RUN;
        end else begin
          ms_cnt_nxt = ms_cnt_r - 24'h00_0001;
        end
      end
      PDWS_RUN: begin
        if (sleep_exec && mode_ok) begin
          state_nxt = PDWS_SLEEP;
          save_nxt = (sleep_mode_select == `PDWS_SM_POWER_SAVE);
        end
      end
      PDWS_SLEEP: begin
        if (any_wake) begin
          state_nxt = PDWS_WAKE;
          ck_cnt_nxt = 4'h0;
        end
      end
      PDWS_WAKE: begin
        if (tick) begin
          if (ck_cnt_r == `PDWS_WAKE_CK - 4'h1) begin
            ck_cnt_nxt = 4'h0;
            state_nxt = PDWS_RUN;
            // Level must still stand after start-up
            level_irq_nxt = wake_s2_r.ext_level;
          end else begin
            ck_cnt_nxt = ck_cnt_r + 4'h1;
          end
        end
      end
      default: begin
        state_nxt = PDWS_RST_CK;
        ck_cnt_nxt = 4'h0;
      end
    endcase
    // Reset requests win over everything, including a wake in progress
    if (rst_req) begin
      state_nxt = PDWS_RST_CK;
      ck_cnt_nxt = 4'h0;
      ms_cnt_nxt = 24'h00_0000;
      save_nxt = 1'b0;
      level_irq_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= PDWS_RST_CK;
      ck_cnt_r <= 4'h0;
      ms_cnt_r <= 24'h00_0000;
      save_r <= 1'b0;
      fuse_r <= `PDWS_FUSE_RST;
    end else begin
      state_r <= state_nxt;
      ck_cnt_r <= ck_cnt_nxt;
      ms_cnt_r <= ms_cnt_nxt;
      save_r <= save_nxt;
      fuse_r <= fuse_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  logic sys_clk_en_r;
  logic core_reset_r;
  logic ext_osc_en_r;
  logic timer_en_r;
  logic level_irq_r;
  logic sleeping_r;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sys_clk_en_r <= 1'b0;
      core_reset_r <= 1'b1;
      ext_osc_en_r <= 1'b1;
      timer_en_r <= 1'b0;
      level_irq_r <= 1'b0;
      sleeping_r <= 1'b0;
    end else begin
      sys_clk_en_r <= (state_nxt == PDWS_RUN);
      core_reset_r <= (state_nxt == PDWS_RST_CK) | (state_nxt == PDWS_RST_MS);
      // Oscillator must run again during wake so the count can advance
      ext_osc_en_r <= (state_nxt != PDWS_SLEEP) & use_ext;
      timer_en_r <= async_timer_async_mode
                  & ((state_nxt == PDWS_RUN)
                  | ((state_nxt == PDWS_SLEEP) & save_nxt));
      level_irq_r <= level_irq_nxt;
      sleeping_r <= (state_nxt == PDWS_SLEEP);
    end
  end

  assign sys_clk_en = sys_clk_en_r;
  assign core_reset_hold = core_reset_r;
  assign ext_osc_en = ext_osc_en_r;
  assign async_timer_en = timer_en_r;
  assign level_irq_req = level_irq_r;
  assign sleeping = sleeping_r;

  ////////////////////////////////////////////////////////////////////
  // Assertions

  AST_SLEEP_ENTRY: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (state_r == PDWS_RUN && sleep_exec && sleep_mode_select == `PDWS_SM_POWER_DOWN && !rst_req)
      |=> (state_r == PDWS_SLEEP) && !sys_clk_en && !save_r
  ) else $error("power-down not entered on sleep strobe");

  AST_SLEEP_STAYS: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (state_r == PDWS_SLEEP && !any_wake) |=> (state_r == PDWS_SLEEP)
  ) else $error("sleep left without a wake event");

  AST_WAKE_COUNT: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (state_r == PDWS_WAKE && state_nxt == PDWS_RUN) |-> (tick && ck_cnt_r == 4'h5)
  ) else $error("wake delay is not six cycles");

  AST_RESET_COUNT: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (state_r == PDWS_RST_CK && state_nxt != PDWS_RST_CK && !rst_req)
      |-> (tick && ck_cnt_r == 4'hD)
  ) else $error("reset delay is not fourteen cycles");

  AST_MS_LOAD: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (state_r == PDWS_RST_CK && state_nxt == PDWS_RST_MS)
      |=> (ms_cnt_r == $past(extra_cyc) - 24'h00_0001)
  ) else $error("extra reset delay loaded wrong");

  AST_TICK_SOURCE: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (fuse_r.clock_source_fuses != 4'h0) |-> (tick == (div_r == INT_DIV_LAST))
  ) else $error("external clock used with non-zero source fuses");

  AST_CLOCKS_HALTED: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (state_r == PDWS_SLEEP) |-> (!sys_clk_en && !ext_osc_en && sleeping)
  ) else $error("clock running during sleep");

  AST_LEVEL_IRQ: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    level_irq_req |-> $past(state_r == PDWS_WAKE && wake_s2_r.ext_level && tick)
  ) else $error("level interrupt without a held level");

  AST_TIMER_SLEEP: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (state_r == PDWS_SLEEP && (!save_r || !$past(async_timer_async_mode)))
      |-> !async_timer_en
  ) else $error("async timer running in sleep outside power-save async mode");

  AST_RELEASE: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    $rose(sys_clk_en) |-> $past(state_r == PDWS_RST_MS || tick)
  ) else $error("core clocks released before count ended");

endmodule

// ---- tb/pdws_far_end.sv ----
// Far-side model: the external clock source feeding the sequencer.
// Assumes the sequencer's oscillator enable starts and stops it.
`timescale 1ns/1ps
module pdws_far_end (
  input wire logic ext_osc_en,
  input wire logic slow,
  output logic external_clock_input
);
  ////////////////////////////////////////////////////////////////////////
  // Fast mode is 20 MHz; slow mode stretches start-up counting
  initial begin
    external_clock_input = 1'b0;
    forever begin
      #(slow ? 60 : 25);
      // Stopped source sits low, never holds its last level high
      external_clock_input = ext_osc_en ? ~external_clock_input : 1'b0;
    end
  end
endmodule

// ---- tb/pdws_sequencer_test.sv ----
// Self-checking bench for the power-down wake sequencer.
// Assumes the far-end clock model and short extra-delay parameters.
`timescale 1ns/1ps
module pdws_sequencer_test;
  import pdws_pkg::*;
  typedef struct {logic irq; longint t0; longint lo; longint hi;} pdws_note_s;
  localparam longint ITK = 7808;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic sleep_exec = 1'b0;
  logic async_timer_async_mode = 1'b0;
  logic slow = 1'b0;
  logic [2:0] sleep_mode_select = 3'h0;
  pdws_fuse_s fuses = '{4'h1, 2'h0};
  pdws_wake_s wake_in = '0;
  logic external_clock_input, sys_clk_en, core_reset_hold, ext_osc_en;
  logic async_timer_en, level_irq_req, sleeping, was_en;
  logic [31:0] rnd;
  logic [2:0] mode_r;
  int miscompares, tests_run;
  pdws_note_s notes[$];
  pdws_note_s cur;

  pdws_sequencer #(.INT_FAST_CYC(20), .INT_SLOW_CYC(40), .EXT_FAST_CYC(21), .EXT_SLOW_CYC(41))
    u_pdws_sequencer (.core_clk(core_clk), .reset_n(reset_n), .sleep_exec(sleep_exec),
    .sleep_mode_select(sleep_mode_select), .fuses(fuses),
    .external_clock_input(external_clock_input), .wake_in(wake_in),
    .async_timer_async_mode(async_timer_async_mode), .sys_clk_en(sys_clk_en),
    .core_reset_hold(core_reset_hold), .ext_osc_en(ext_osc_en),
    .async_timer_en(async_timer_en), .level_irq_req(level_irq_req), .sleeping(sleeping));
  pdws_far_end u_pdws_far_end (.ext_osc_en(ext_osc_en), .slow(slow),
    .external_clock_input(external_clock_input));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (exp !== got) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic check_win(input string what, input longint lo, hi, got);
    tests_run++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic note(input logic irq, input longint lo, hi);
    notes.push_back('{irq, $time, lo, hi});
  endtask
  // Bounded so a stuck sequencer is reported, not hung on
  // Samples on the falling edge, returns on a rising one for the next drive
  task automatic wait_up();
    int n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (sys_clk_en !== 1'b1 && n < 20000);
    if (n >= 20000) check("sys_clk_en rise", 1, 0);
    check("core_reset_hold", 0, core_reset_hold);
    @(posedge core_clk);
  endtask
  task automatic do_reset(input longint lo, hi);
    reset_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    check("core_reset_hold", 1, core_reset_hold);
    reset_n <= 1'b1;
    note(1'b0, lo, hi);
    wait_up();
  endtask
  task automatic go_sleep(input logic [2:0] mode, input logic take);
    @(posedge core_clk);
    sleep_exec <= 1'b1;
    sleep_mode_select <= mode;
    @(posedge core_clk);
    sleep_exec <= 1'b0;
    @(negedge core_clk);
    check("sleeping", take, sleeping);
    check("sys_clk_en", !take, sys_clk_en);
  endtask
  // Zero hold keeps the source up until the clocks return
  task automatic wake_by(input int b, hold, input logic irq, input longint lo, hi);
    @(posedge core_clk);
    wake_in[b] <= 1'b1;
    note(irq, lo, hi);
    if (hold > 0) repeat (hold) @(posedge core_clk);
    else wait_up();
    wake_in[b] <= 1'b0;
    if (hold > 0) wait_up();
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  // Falling edge: outputs launched on the rising edge have settled
  always @(negedge core_clk) begin
    was_en <= sys_clk_en;
    if (reset_n === 1'b1 && sys_clk_en === 1'b1 && was_en === 1'b0) begin
      if (notes.size() == 0) check("pending note", 1, 0);
      else begin
        cur = notes.pop_front();
        check("level_irq_req", cur.irq, level_irq_req);
        check_win("start-up ns", cur.lo, cur.hi, $time - cur.t0);
      end
    end
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    miscompares++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rnd = 32'h671e_3545;
    // Fuse register starts on external, so allow two ticks of slack
    do_reset(12 * ITK, 14 * ITK + 300);
    go_sleep(3'h2, 1'b1);
    check("ext_osc_en", 0, ext_osc_en);
    wake_by(2, 4, 1'b0, 5 * ITK, 6 * ITK + 300);
    $display("Internal clock tests done");
    // Windows overlap only at 780..800 and at 950, away from where the three start-up codes land
    fuses <= '{4'h0, 2'h1};
    do_reset(780, 950);
    check("ext_osc_en", 1, ext_osc_en);
    for (int b = 8; b >= 2; b--) begin
      go_sleep(3'h2, 1'b1);
      check("ext_osc_en", 0, ext_osc_en);
      if (b == 8 || b == 7 || b == 5) wake_by(b, 4, 1'b0, 700, 1200);
      else wake_by(b, 4, 1'b0, 250, 650);
    end
    go_sleep(3'h2, 1'b1);
    wake_by(3, 0, 1'b1, 250, 650);
    $display("External clock wake tests done");
    fuses <= '{4'h0, 2'h2};
    do_reset(950, 1300);
    // Reserved code adds no extra delay
    fuses <= '{4'h0, 2'h3};
    do_reset(600, 800);
    $display("Start-up code tests done");
    async_timer_async_mode <= 1'b1;
    repeat (4) begin
      rnd = lfsr(rnd);
      mode_r = rnd[2:0] | {rnd[2:1] == 2'b01, 2'b00};
      go_sleep(mode_r, 1'b0);
      check("async_timer_en", 1, async_timer_en);
    end
    go_sleep(3'h2, 1'b1);
    check("async_timer_en", 0, async_timer_en);
    @(posedge core_clk);
    wake_in.async_timer_irq <= 1'b1;
    repeat (50) @(posedge core_clk);
    wake_in.async_timer_irq <= 1'b0;
    check("sleeping", 1, sleeping);
    wake_by(4, 4, 1'b0, 250, 650);
    $display("Refusal tests done");
    slow <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      go_sleep(3'h3, 1'b1);
      check("async_timer_en", 1, async_timer_en);
      wake_by(b, 4, 1'b0, 600, 1100);
    end
    $display("Power-save tests done");
    check("notes left", 0, notes.size());
    complete_run();
  end
endmodule
